//--- bench/parallel_eeprom_byte_page_write_bench.sv
// Self-checking bench: host controller against the memory model
module parallel_eeprom_byte_page_write_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0; // 100 MHz
  logic reset_i = 1'b1; // Held 20 cycles
  logic req_valid_i = 1'b0;
  pee_pkg::pee_req_t req_i = '0;
  logic req_ready_o, rsp_valid_o, timeout_o, mem_dq_oe_o;
  logic [7:0] rsp_data_o, mem_dq_o, bus;
  logic [12:0] mem_addr_o;
  pee_pkg::pee_pins_t mem_pins_o;
  int err_count = 0;
  int compares = 0;
  int strobes = 0; // Strobe falls in the current page
  int low_run = 0; // Length of the current strobe pulse
  int n;
  logic [8:0] exp_page = '0; // Page the strobes must stay in
  logic [7:0] d;
  logic t;
  always #5 core_clk_i = ~core_clk_i;
  pee_host i_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_data_o(rsp_data_o), .timeout_o(timeout_o), .mem_addr_o(mem_addr_o),
    .mem_dq_o(mem_dq_o), .mem_dq_oe_o(mem_dq_oe_o), .mem_dq_i(bus), .mem_pins_o(mem_pins_o));
  pee_mem_model i_mem (.core_clk_i(core_clk_i), .addr_i(mem_addr_o), .host_dq_i(mem_dq_o),
    .host_oe_i(mem_dq_oe_o), .pins_i(mem_pins_o), .bus_o(bus));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // A wait ran out of its bound
  task automatic hang();
    err_count++;
    give_verdict();
  endtask
  // One request, held until taken, then one idle edge
  task automatic send(input pee_pkg::pee_cmd_t c, input logic l, input logic [12:0] a,
                      input logic [7:0] v);
    req_valid_i <= 1'b1;
    req_i <= '{c, l, a, v};
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 5000);
    req_valid_i <= 1'b0;
    if (n >= 5000) hang();
    @(posedge core_clk_i);
  endtask
  // Wait for the one-cycle answer
  task automatic wait_rsp(input int bound);
    for (n = 0; n < bound && rsp_valid_o !== 1'b1; n++) @(posedge core_clk_i);
    if (n >= bound) hang();
    d = rsp_data_o;
    t = timeout_o;
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] exp);
    send(pee_pkg::PEE_CMD_READ, 1'b1, a, 8'h00);
    wait_rsp(200);
    check("read data", 16'(d), 16'(exp));
  endtask
  // Page of cnt bytes, closed by the last flag or else by the host itself
  task automatic wr_page(input logic [12:0] a, input int cnt, input logic [7:0] v0,
                         input logic l);
    exp_page = a[12:4];
    strobes = 0;
    for (int i = 0; i < cnt; i++) begin
      send(pee_pkg::PEE_CMD_WRITE, l && i == cnt - 1, a + 13'(i), v0 + 8'(i));
    end
    wait_rsp(30000);
    check("poll timeout", 16'(t), 16'h0);
    check("strobes in page", 16'(strobes), 16'(cnt));
    for (int i = 0; i < cnt; i++) rd(a + 13'(i), v0 + 8'(i));
  endtask
  // Pin watch on every edge outside reset
  always @(posedge core_clk_i) begin
    if (!reset_i) begin
      if (mem_dq_oe_o === 1'b1 && !mem_pins_o.erase_hv) begin
        check("enable while driving", 16'(mem_pins_o.oe_n), 16'h1);
      end
      if (mem_pins_o.we_n === 1'b0) begin
        check("select in strobe", 16'(mem_pins_o.sel_n), 16'h0);
        if (low_run == 0 && !mem_pins_o.erase_hv) begin
          strobes <= strobes + 1;
          check("page bits", 16'(mem_addr_o[12:4]), 16'(exp_page));
        end
        low_run <= low_run + 1;
      end else if (low_run > 0) begin
        check("strobe width", 16'(low_run >= pee_pkg::STROBE_LOW_CYC), 16'h1);
        low_run <= 0;
      end
    end
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk_i);
    check("reset pins", 16'({mem_pins_o, mem_dq_oe_o, req_ready_o}), 16'h38);
    reset_i <= 1'b0;
    @(posedge core_clk_i);
    rd(13'h1fff, 8'hff);
    wr_page(13'h0123, 1, 8'h5a, 1'b1);
    wr_page(13'h0124, 1, 8'ha5, 1'b1);
    wr_page(13'h01a0, 16, 8'h30, 1'b0);
    wr_page(13'h0450, 3, 8'hc0, 1'b0);
    send(pee_pkg::PEE_CMD_ERASE, 1'b1, 13'h0000, 8'hff);
    for (n = 0; n < 300 && mem_pins_o.we_n !== 1'b0; n++) @(posedge core_clk_i);
    if (n >= 300) hang();
    check("erase pins", 16'({mem_pins_o, mem_dq_oe_o, mem_dq_o}), 16'h0bff);
    reset_i <= 1'b1;
    repeat (20) @(posedge core_clk_i);
    check("pins after reset", 16'({mem_pins_o, mem_dq_oe_o}), 16'h1c);
    give_verdict();
  end
endmodule // parallel_eeprom_byte_page_write_bench

//--- bench/pee_mem_model.sv
// Behavioural byte-wide nonvolatile memory, seen only through its pins
module pee_mem_model #(
  parameter int WINDOW_CYC = 2000, // Byte-load window, 20 us
  parameter int PROG_CYC = 1500, // Programming time, shortened to keep runs short
  parameter int ERASE_CYC = 3000 // Erase time, shortened likewise
) (
  input wire logic core_clk_i,
  input wire logic [12:0] addr_i,
  input wire logic [7:0] host_dq_i,
  input wire logic host_oe_i,
  input wire pee_pkg::pee_pins_t pins_i,
  output logic [7:0] bus_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [8192]; // Array, erased state is all ones
  logic [12:0] pg_addr [16]; // Page buffer
  logic [7:0] pg_data [16];
  logic [12:0] cap_addr, last_addr;
  logic [7:0] last_data, prev_bus;
  logic wr, wr_q, erasing;
  int nbuf, win, busy, low_cyc;
  // Write needs select and strobe low with enable high or erase raised
  assign wr = !pins_i.sel_n && !pins_i.we_n && (pins_i.oe_n || pins_i.erase_hv);
  // Power-up state
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    nbuf = 0;
    win = 0;
    busy = 0;
    low_cyc = 0;
    wr_q = 1'b0;
    erasing = 1'b0;
    prev_bus = 8'h00;
  end
  // Bus level; a released bus toggles so a stale value can never pass
  always_comb begin
    if (host_oe_i) begin
      bus_o = host_dq_i;
    end else if (!pins_i.sel_n && !pins_i.oe_n && pins_i.we_n) begin
      bus_o = mem[addr_i];
      if ((busy > 0 || nbuf > 0) && addr_i == last_addr) begin
        bus_o[7] = ~last_data[7];
      end
    end else begin
      bus_o = ~prev_bus; // Released
    end
  end
  // Strobe edges, page buffer, window and self-timed programming
  always @(posedge core_clk_i) begin
    prev_bus <= bus_o;
    wr_q <= wr;
    low_cyc <= wr ? low_cyc + 1 : 0;
    if (win > 0) win <= win - 1;
    if (busy > 0) busy <= busy - 1;
    if (wr && !wr_q && busy == 0) begin // Address on the later fall
      cap_addr <= addr_i;
      win <= WINDOW_CYC;
    end
    if (!wr && wr_q && low_cyc >= 2 && busy == 0) begin // Data on first rise
      if (pins_i.erase_hv && bus_o == 8'hff) begin
        busy <= ERASE_CYC;
        erasing <= 1'b1;
      end else if (nbuf < 16) begin
        pg_addr[nbuf] <= cap_addr;
        pg_data[nbuf] <= bus_o;
        nbuf <= nbuf + 1;
        last_addr <= cap_addr;
        last_data <= bus_o;
      end
    end
    if (win == 1 && nbuf > 0) busy <= PROG_CYC; // Window expired
    if (busy == 1) begin
      if (erasing) foreach (mem[i]) mem[i] <= 8'hff;
      else for (int i = 0; i < nbuf; i++) mem[pg_addr[i]] <= pg_data[i];
      nbuf <= 0;
      erasing <= 1'b0;
    end
  end
endmodule // pee_mem_model

//--- core/pee_host.sv
// Host controller for a byte-wide electrically erasable memory
module pee_host (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic req_valid_i,
  input wire pee_pkg::pee_req_t req_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [pee_pkg::DATA_W-1:0] rsp_data_o,
  output logic timeout_o,
  output logic [pee_pkg::ADDR_W-1:0] mem_addr_o,
  output logic [pee_pkg::DATA_W-1:0] mem_dq_o,
  output logic mem_dq_oe_o,
  input wire logic [pee_pkg::DATA_W-1:0] mem_dq_i,
  output pee_pkg::pee_pins_t mem_pins_o
);
  // Machine states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_RD_ACC = 4'h1,
    ST_WR_SETUP = 4'h2,
    ST_WR_LOW = 4'h3,
    ST_WR_HIGH = 4'h4,
    ST_PAGE_WAIT = 4'h5,
    ST_POLL_ACC = 4'h6,
    ST_POLL_GAP = 4'h7,
    ST_ERASE = 4'h8,
    ST_RSP = 4'h9
  } pee_state_t;
  localparam int CW = 24;
  // Cycle counts at counter width
  localparam logic [CW-1:0] LOW_CYC = CW'(pee_pkg::STROBE_LOW_CYC);
  localparam logic [CW-1:0] HIGH_CYC = CW'(pee_pkg::STROBE_HIGH_CYC);
  localparam logic [CW-1:0] ACC_CYC = CW'(pee_pkg::READ_ACCESS_CYC + 2);
  localparam logic [CW-1:0] ERASE_CYC = CW'(pee_pkg::ERASE_CYC);
  localparam logic [CW-1:0] POLL_CYC = CW'(pee_pkg::POLL_LIMIT_CYC);
  // Leave margin below the window so the next fall lands inside it
  localparam logic [CW-1:0] WIN_CYC = CW'(pee_pkg::BYTE_LOAD_WINDOW_CYC / 2);
  localparam int NCNT = $clog2(pee_pkg::PAGE_BYTES + 1);
  // Synchronised data lines, read back from the pins
  logic [pee_pkg::DATA_W-1:0] dq_sync;
  pee_sync #(.WIDTH(pee_pkg::DATA_W)) u_sync (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .d_i(mem_dq_i),
    .q_o(dq_sync)
  );
  // State registers
  pee_state_t state, next_state;
  logic [CW-1:0] cnt, next_cnt;
  logic [CW-1:0] win, next_win;
  logic [CW-1:0] poll, next_poll;
  logic [NCNT-1:0] nbytes, next_nbytes;
  logic [pee_pkg::ADDR_W-pee_pkg::PAGE_LSB-1:0] page, next_page;
  logic [pee_pkg::ADDR_W-1:0] last_addr, next_last_addr;
  logic last_bit7, next_last_bit7;
  logic last_req, next_last_req;
  logic erase_mode, next_erase_mode;
  // Output registers
  logic next_ready, next_rsp_valid, next_timeout, next_dq_oe;
  logic [pee_pkg::DATA_W-1:0] next_rsp_data, next_dq;
  logic [pee_pkg::ADDR_W-1:0] next_addr;
  pee_pkg::pee_pins_t next_pins;
  logic take;
  logic same_page;
  always_comb take = req_valid_i && req_ready_o;
  always_comb same_page = req_i.addr[pee_pkg::ADDR_W-1:pee_pkg::PAGE_LSB] == page;
  // Sequencer next values
  always_comb begin
    next_state = state;
    next_cnt = (cnt != '0) ? cnt - 1'b1 : cnt;
    next_win = (win != '0) ? win - 1'b1 : win;
    next_poll = (poll != '0) ? poll - 1'b1 : poll;
    next_nbytes = nbytes;
    next_page = page;
    next_last_addr = last_addr;
    next_last_bit7 = last_bit7;
    next_last_req = last_req;
    next_erase_mode = erase_mode;
    next_ready = 1'b0;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data_o;
    next_timeout = 1'b0;
    next_addr = mem_addr_o;
    next_dq = mem_dq_o;
    next_dq_oe = mem_dq_oe_o;
    next_pins = mem_pins_o;
    case (state)
      ST_IDLE, ST_PAGE_WAIT: begin
        // Page close: window lapsed or last byte flagged
        // A byte taken on the closing edge wins; the halved window leaves room for it
        if (state == ST_PAGE_WAIT && (win == '0 || last_req) && !take) begin
          next_state = ST_POLL_ACC;
          next_poll = POLL_CYC;
          next_addr = last_addr;
          next_pins.oe_n = 1'b0;  // Read last byte for polling
          next_pins.sel_n = 1'b0;
          next_cnt = ACC_CYC;
        end else if (take) begin
          next_addr = req_i.addr;  // Thirteen bits select one byte
          next_last_req = req_i.last;
          if (req_i.cmd == pee_pkg::PEE_CMD_READ && state == ST_IDLE) begin
            // Select and enable low, strobe high, bus released
            next_pins.sel_n = 1'b0;
            next_pins.oe_n = 1'b0;
            next_dq_oe = 1'b0;
            next_cnt = ACC_CYC;
            next_state = ST_RD_ACC;
          end else begin
            // Enable high before the strobe falls
            next_pins.oe_n = 1'b1;
            next_pins.sel_n = 1'b0;
            next_erase_mode = req_i.cmd == pee_pkg::PEE_CMD_ERASE;
            next_pins.erase_hv = req_i.cmd == pee_pkg::PEE_CMD_ERASE;
            // Erase needs all data lines high
            next_dq = (req_i.cmd == pee_pkg::PEE_CMD_ERASE) ? '1 : req_i.data;
            next_dq_oe = 1'b1;
            next_page = req_i.addr[pee_pkg::ADDR_W-1:pee_pkg::PAGE_LSB];
            next_last_addr = req_i.addr;
            next_last_bit7 = req_i.data[pee_pkg::DATA_W-1];
            next_cnt = HIGH_CYC;
            next_state = ST_WR_SETUP;
          end
        end else if (state == ST_IDLE) begin
          next_ready = 1'b1;
          next_pins.sel_n = 1'b1;  // Idle in standby
        end else begin
          next_ready = 1'b1;
        end
      end
      ST_RD_ACC: begin
        if (cnt == '0) begin
          next_rsp_data = dq_sync;
          next_pins.oe_n = 1'b1;  // End read, device releases bus
          next_pins.sel_n = 1'b1;
          next_state = ST_RSP;
        end
      end
      ST_WR_SETUP: begin
        if (cnt == '0) begin
          // Strobe falls last, address taken here
          next_pins.we_n = 1'b0;
          next_cnt = LOW_CYC;
          next_win = WIN_CYC;  // Window restarts on each fall
          next_nbytes = nbytes + 1'b1;
          next_state = ST_WR_LOW;
        end
      end
      ST_WR_LOW: begin
        // Pulse far above the glitch floor
        if (cnt == '0) begin
          next_pins.we_n = 1'b1;  // Strobe rises first, data taken
          next_cnt = HIGH_CYC;
          next_state = ST_WR_HIGH;
        end
      end
      ST_WR_HIGH: begin
        if (cnt == '0) begin
          next_dq_oe = 1'b0;
          if (erase_mode) begin
            next_pins.erase_hv = 1'b0;
            next_pins.sel_n = 1'b1;
            next_cnt = ERASE_CYC;  // Erase done in fixed time
            next_state = ST_ERASE;
          end else if (nbytes == NCNT'(pee_pkg::PAGE_BYTES) || last_req) begin
            // Page full or last byte flagged; no more than sixteen bytes
            next_pins.sel_n = 1'b1;
            next_last_req = 1'b1;
            next_state = ST_PAGE_WAIT;
          end else begin
            next_ready = 1'b1;
            next_state = ST_PAGE_WAIT;
          end
        end
      end
      ST_POLL_ACC: begin
        if (cnt == '0) begin
          next_pins.oe_n = 1'b1;
          next_pins.sel_n = 1'b1;
          next_cnt = HIGH_CYC;
          next_state = ST_POLL_GAP;
          // True bit 7 means done
          if (dq_sync[pee_pkg::DATA_W-1] == last_bit7 || poll == '0) begin
            next_timeout = poll == '0;
            next_state = ST_RSP;
          end
        end
      end
      ST_POLL_GAP: begin
        if (cnt == '0) begin
          next_pins.oe_n = 1'b0;
          next_pins.sel_n = 1'b0;
          next_cnt = ACC_CYC;
          next_state = ST_POLL_ACC;
        end
      end
      ST_ERASE: begin
        if (cnt == '0) begin
          next_state = ST_RSP;
        end
      end
      default: begin
        // ST_RSP: one-cycle answer
        next_rsp_valid = 1'b1;
        next_nbytes = '0;
        next_last_req = 1'b0;
        next_erase_mode = 1'b0;
        next_state = ST_IDLE;
      end
    endcase
  end
  // Register everything
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
      cnt <= '0;
      win <= '0;
      poll <= '0;
      nbytes <= '0;
      page <= '0;
      last_addr <= '0;
      last_bit7 <= 1'b0;
      last_req <= 1'b0;
      erase_mode <= 1'b0;
      req_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_data_o <= '0;
      timeout_o <= 1'b0;
      mem_addr_o <= '0;
      mem_dq_o <= '0;
      mem_dq_oe_o <= 1'b0;
      mem_pins_o <= 4'he;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      win <= next_win;
      poll <= next_poll;
      nbytes <= next_nbytes;
      page <= next_page;
      last_addr <= next_last_addr;
      last_bit7 <= next_last_bit7;
      last_req <= next_last_req;
      erase_mode <= next_erase_mode;
      req_ready_o <= next_ready;
      rsp_valid_o <= next_rsp_valid;
      rsp_data_o <= next_rsp_data;
      timeout_o <= next_timeout;
      mem_addr_o <= next_addr;
      mem_dq_o <= next_dq;
      mem_dq_oe_o <= next_dq_oe;
      mem_pins_o <= next_pins;
    end
  end
  // Strobe low only with select low and enable high
  property p_write_combo;
    @(posedge core_clk_i) disable iff (reset_i)
      !mem_pins_o.we_n |-> (!mem_pins_o.sel_n && mem_pins_o.oe_n);
  endproperty
  a_write_combo: assert property (p_write_combo) else $error("Bad write combination");
  // Never drive the bus while reading
  property p_no_contention;
    @(posedge core_clk_i) disable iff (reset_i)
      !mem_pins_o.oe_n |-> !mem_dq_oe_o;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("Bus contention");
  // Strobe pulse lasts more than two cycles
  property p_pulse_width;
    @(posedge core_clk_i) disable iff (reset_i)
      $fell(mem_pins_o.we_n) |-> !mem_pins_o.we_n [*3];
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("Strobe too short");
  // Data held steady while strobe low
  property p_data_stable;
    @(posedge core_clk_i) disable iff (reset_i)
      !mem_pins_o.we_n |-> $stable(mem_dq_o) && mem_dq_oe_o;
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("Data moved");
  // Erase drives all ones
  property p_erase_ones;
    @(posedge core_clk_i) disable iff (reset_i)
      (mem_pins_o.erase_hv && !mem_pins_o.we_n) |-> mem_dq_o == '1;
  endproperty
  a_erase_ones: assert property (p_erase_ones) else $error("Erase data not ones");
  // Page bits fixed across a page
  property p_same_page;
    @(posedge core_clk_i) disable iff (reset_i)
      (state == ST_PAGE_WAIT && take) |-> same_page;
  endproperty
  a_same_page: assert property (p_same_page) else $error("Page changed");
endmodule // pee_host

//--- core/pee_pkg.sv
package pee_pkg;
  // Clock period in ns
  localparam int CLK_NS = 10;
  // Array shape
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int PAGE_LSB = 4;
  localparam int PAGE_BYTES = 16;
  // Byte-load window, longest gap between strobe falls, in ns
  localparam int BYTE_LOAD_WINDOW_NS = 20000;
  // Longest time rounds down
  localparam int BYTE_LOAD_WINDOW_CYC = BYTE_LOAD_WINDOW_NS / CLK_NS;
  // Strobe pulse width held by the host, in ns (above the 20 ns glitch floor)
  localparam int STROBE_LOW_NS = 150;
  // Least time rounds up
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS + CLK_NS - 1) / CLK_NS;
  // Strobe high recovery and select setup/hold, in ns
  localparam int STROBE_HIGH_NS = 50;
  localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  // Output enable access time, in ns
  localparam int READ_ACCESS_NS = 150;
  localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  // Erase completion time in ns
  localparam int ERASE_NS = 10000000;
  localparam int ERASE_CYC = ERASE_NS / CLK_NS;
  // Poll timeout in ns (beyond the longest write cycle)
  localparam int POLL_LIMIT_NS = 20000000;
  localparam int POLL_LIMIT_CYC = POLL_LIMIT_NS / CLK_NS;
  // Command codes
  typedef enum logic [1:0] {
    PEE_CMD_READ = 2'h0,
    PEE_CMD_WRITE = 2'h1,
    PEE_CMD_ERASE = 2'h2
  } pee_cmd_t;
  // Request from the user side
  typedef struct packed {
    pee_cmd_t cmd;
    logic last;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pee_req_t;
  // Control pins toward the memory, all active low except erase
  typedef struct packed {
    logic sel_n;
    logic oe_n;
    logic we_n;
    logic erase_hv;
  } pee_pins_t;
endpackage

//--- core/pee_sync.sv
// Two-stage synchroniser for the returning data lines
module pee_sync #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  // Refuse an empty bus at elaboration
  if (WIDTH < 1) begin : g_width_check
    $error("Synchroniser width must be at least one");
  end
  // First stage is read only by the second
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_q;
  // Next values
  always_comb begin
    next_meta = d_i;
    next_q = meta;
  end
  // Registers
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= next_meta;
      q_o <= next_q;
    end
  end
endmodule // pee_sync
